/* src/sasc_sequencer.sv */
// Converter channel sequencer with per-channel results and range check
// Behaviour
// RULE1 - Results are 12 bits, up to 1 Msps
// RULE2 - Converter clock at most 18 MHz, 18 clocks
// RULE3 - Eight-input sequencer scans selected channels autonomously
// RULE4 - No idle cycles between channels
// RULE5 - Hardware scan or firmware-selected channel
// RULE6 - One result buffer per channel
// RULE7 - Per-channel sample time applied on sampling
// RULE8 - Low/high limits raise out-of-range flag
// RULE9 - Range checked on each conversion completion
// RULE10 - Four reference choices including external pin
// RULE11 - Programmable sample-and-hold window
// RULE12 - Temperature sensor routable to converter
// RULE13 - Converter held off in deep sleep
// RULE14 - Flag sticky; equal to limit is in range
`timescale 1ns/1ps
`include "sasc_consts.svh"
module sasc_sequencer
  import sasc_pkg::*;
(
  input  wire logic        mclk,        // System clock 250 MHz
  input  wire logic        reset_n,     // Sync reset, active low
  input  wire logic        enable,      // Converter enable
  input  wire logic        deepSleep,   // Deep sleep or hibernate
  input  wire logic        hwScan,      // 1 hardware scan, 0 firmware
  input  wire logic [7:0]  chanEn,      // Scan channel selection
  input  wire logic [2:0]  fwChan,      // Firmware-selected channel
  input  wire logic        fwStart,     // Firmware conversion pulse
  input  wire logic        tempSel,     // Route temperature sensor
  input  wire sasc_ref_t   refSelIn,    // Reference selection
  input  wire logic [4:0]  clkDiv,      // Converter clock divide
  input  wire logic [63:0] sampTimes,   // Sample ticks per channel
  input  wire logic [11:0] limitLo,     // Low range limit
  input  wire logic [11:0] limitHi,     // High range limit
  input  wire logic        rangeClr,    // Clear out-of-range flag
  input  wire logic        coreBit,     // Comparator decision bit
  input  wire logic [2:0]  rdChan,      // Result read channel
  output sasc_ref_t        refSel,      // Reference to analog core
  output logic [2:0]       muxSel,      // Analog input mux select
  output logic             muxTemp,     // Temperature sensor on mux
  output logic             sampleOn,    // Sample switch closed
  output logic [11:0]      dacCode,     // Trial code to core
  output logic             adcTick,     // Converter clock tick
  output logic             busy,        // Conversion in progress
  output logic             done,        // One-cycle conversion done
  output sasc_result_t     lastResult,  // Last completed result
  output sasc_result_t     rdResult,    // Selected channel result
  output logic [7:0]       rangeFlags,  // Per-channel out of range
  output logic             rangeIrq     // Sticky out-of-range flag
);
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b10
  } sasc_state_t;

  //////////////////////////////////////////////////////////////////////////
  sasc_state_t  state_q, state_d;
  logic [2:0]   chan_q, chan_d;
  logic [7:0]   samp_q, samp_d;
  logic [4:0]   bitCnt_q, bitCnt_d;
  logic [11:0]  sar_q, sar_d;
  logic [11:0]  buf_q [`SASC_NCH];
  logic [7:0]   bufValid_q;
  logic [7:0]   rangeFlags_q;
  logic         irq_q;
  logic         done_q;
  sasc_result_t last_q;
  sasc_result_t rd_q;
  logic         run;
  logic [2:0]   nextChan;
  logic [11:0]  finalCode;
  logic         outOfRange;
  logic         convEnd;

  // Next enabled channel after the given one
  function automatic logic [2:0] next_en(input logic [2:0] cur,
                                         input logic [7:0] en);
    logic [2:0] c;
    logic       found;
    c = cur;
    found = 1'b0;
    for (int i = 1; i <= 8; i++)
    begin
      if (!found && en[3'(cur + 3'(i))])
      begin
        c = 3'(cur + 3'(i));
        found = 1'b1;
      end
    end
    return c;
  endfunction

  // RULE2 floor on sample ticks
  // Keeps sample plus approximation at 18 ticks or more
  function automatic logic [7:0] samp_len(input logic [7:0] req);
    logic [7:0] minLen;
    minLen = 8'(`SASC_CONV_CLKS - `SASC_RES_W);
    return (req < minLen) ? minLen : req;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // RULE13 deep sleep gating
  assign run = enable && !deepSleep;

  // RULE2 clamped converter clock
  sasc_clkdiv u_div (
    .mclk    (mclk),
    .reset_n (reset_n),
    .divSel  (clkDiv),
    .run     (run),
    .adcTick (adcTick)
  );

  // RULE10 reference pass-through
  assign refSel = refSelIn;
  assign nextChan = hwScan ? next_en(chan_q, chanEn) : fwChan;
  // RULE12 temperature routing
  assign muxTemp = tempSel && (chan_q == `SASC_TEMP_CH);
  assign muxSel = chan_q;
  assign sampleOn = (state_q == ST_SAMPLE);
  assign busy = (state_q != ST_IDLE);
  assign done = done_q;
  assign dacCode = sar_q;
  assign finalCode = coreBit ? sar_q : (sar_q & ~(12'h800 >> bitCnt_q));
  assign convEnd = (state_q == ST_CONV) && adcTick
                   && (bitCnt_q == 5'(`SASC_RES_W - 1));
  // RULE14 limits inclusive
  assign outOfRange = (finalCode < limitLo) || (finalCode > limitHi);

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_d = state_q;
    chan_d = chan_q;
    samp_d = samp_q;
    bitCnt_d = bitCnt_q;
    sar_d = sar_q;
    unique case (state_q)
      ST_IDLE:
      begin
        // RULE5 hardware or firmware start
        if (run && ((hwScan && chanEn != 8'h00) || (!hwScan && fwStart)))
        begin
          chan_d = hwScan ? (chanEn[chan_q] ? chan_q : nextChan) : fwChan;
          state_d = ST_SAMPLE;
          // RULE7 channel sample time
          samp_d = samp_len(sampTimes[8*chan_d +: 8]);
        end
      end
      ST_SAMPLE:
      begin
        // RULE11 programmable acquisition
        if (adcTick)
        begin
          if (samp_q <= 8'h01)
          begin
            state_d = ST_CONV;
            bitCnt_d = 5'h00;
            sar_d = 12'h800;
          end
          else
            samp_d = samp_q - 8'h01;
        end
      end
      ST_CONV:
      begin
        // RULE1 twelve-bit approximation
        if (adcTick)
        begin
          if (convEnd)
          begin
            sar_d = finalCode;
            // RULE3 RULE4 straight to next channel
            if (run && hwScan && chanEn != 8'h00)
            begin
              chan_d = nextChan;
              state_d = ST_SAMPLE;
              samp_d = samp_len(sampTimes[8*nextChan +: 8]);
            end
            else
              state_d = ST_IDLE;
          end
          else
          begin
            sar_d = finalCode | (12'h400 >> bitCnt_q);
            bitCnt_d = bitCnt_q + 5'h01;
          end
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
    if (!run)
      state_d = ST_IDLE;
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      chan_q <= 3'h0;
      samp_q <= `SASC_SAMP_RST;
      bitCnt_q <= 5'h00;
      sar_q <= 12'h000;
    end
    else
    begin
      state_q <= state_d;
      chan_q <= chan_d;
      samp_q <= samp_d;
      bitCnt_q <= bitCnt_d;
      sar_q <= sar_d;
    end
  end

  // RULE6 per-channel result buffers
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      bufValid_q <= 8'h00;
      last_q <= '0;
      done_q <= 1'b0;
      rd_q <= '0;
      for (int i = 0; i < `SASC_NCH; i++)
        buf_q[i] <= 12'h000;
    end
    else
    begin
      done_q <= convEnd;
      rd_q <= '{valid: bufValid_q[rdChan], chan: rdChan,
                value: buf_q[rdChan]};
      if (convEnd)
      begin
        buf_q[chan_q] <= finalCode;
        bufValid_q[chan_q] <= 1'b1;
        last_q <= '{valid: 1'b1, chan: chan_q, value: finalCode};
      end
    end
  end

  // RULE8 RULE9 RULE14 sticky range flag, set wins
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      irq_q <= 1'b0;
      rangeFlags_q <= 8'h00;
    end
    else
    begin
      if (convEnd && outOfRange)
      begin
        irq_q <= 1'b1;
        rangeFlags_q <= (rangeClr ? 8'h00 : rangeFlags_q)
                        | (8'h01 << chan_q);
      end
      else if (rangeClr)
      begin
        irq_q <= 1'b0;
        rangeFlags_q <= 8'h00;
      end
    end
  end

  assign lastResult = last_q;
  assign rdResult = rd_q;
  assign rangeFlags = rangeFlags_q;
  assign rangeIrq = irq_q;
endmodule

/* shared/sasc_consts.svh */
// Constants for the converter sequencer control block
`ifndef SASC_CONSTS_SVH
`define SASC_CONSTS_SVH
`define SASC_RES_W          12
`define SASC_NCH            8
`define SASC_CH_W           3
`define SASC_MCLK_MHZ       250
`define SASC_ADC_MAX_MHZ    18
`define SASC_CONV_CLKS      18
`define SASC_DIV_MIN        ((`SASC_MCLK_MHZ + `SASC_ADC_MAX_MHZ - 1) / `SASC_ADC_MAX_MHZ)
`define SASC_SAMP_W         8
`define SASC_SAMP_RST       8'h04
`define SASC_TEMP_CH        3'h7
`define SASC_CNT_W          5
`endif

/* shared/sasc_pkg.sv */
// Types for the converter sequencer control block
package sasc_pkg;
  typedef enum logic [1:0] {
    REF_VDD     = 2'b00,
    REF_VDDHALF = 2'b01,
    REF_INT     = 2'b10,
    REF_EXT     = 2'b11
  } sasc_ref_t;
  typedef struct packed {
    logic        valid;
    logic [2:0]  chan;
    logic [11:0] value;
  } sasc_result_t;
endpackage

/* src/sasc_clkdiv.sv */
// Converter clock tick generator
`timescale 1ns/1ps
`include "sasc_consts.svh"
module sasc_clkdiv
  import sasc_pkg::*;
(
  input  wire logic       mclk,     // System clock
  input  wire logic       reset_n,  // Sync reset
  input  wire logic [4:0] divSel,   // Requested divide
  input  wire logic       run,      // Divider enable
  output logic            adcTick   // Converter clock tick
);
  localparam logic [4:0] DIV_MIN = 5'(`SASC_DIV_MIN);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] divEff;
  // Clamp keeps converter clock at or under 18 MHz
  assign divEff = (divSel < DIV_MIN) ? DIV_MIN : divSel;
  assign cnt_d = (!run || cnt_q == divEff - 5'h01) ? 5'h00 : cnt_q + 5'h01;
  assign adcTick = run && (cnt_q == divEff - 5'h01);
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      cnt_q <= 5'h00;
    else
      cnt_q <= cnt_d;
  end
endmodule

/* tb/sasc_core_model.sv */
// Comparator model of the analog converter core
`timescale 1ns/1ps
module sasc_core_model
(
  input  wire logic [2:0]  muxSel,   // Input select
  input  wire logic        muxTemp,  // Sensor select
  input  wire logic        sampleOn, // Sampling
  input  wire logic [11:0] dacCode,  // Trial code
  input  wire logic [95:0] vals,     // Pin levels
  input  wire logic [11:0] tempVal,  // Sensor level
  output logic             coreBit   // Decision
);
  logic [11:0] vin;
  assign vin = muxTemp ? tempVal : vals[muxSel*12 +: 12];
  assign coreBit = sampleOn ? ~dacCode[0] : (vin >= dacCode);
endmodule

/* tb/sasc_sequencer_sva.sv */
// Port checker for the sequencer
`timescale 1ns/1ps
`include "sasc_consts.svh"
module sasc_sequencer_sva
  import sasc_pkg::*;
(
  input  wire logic         mclk,        // System clock
  input  wire logic         reset_n,     // Sync reset
  input  wire logic         enable,      // Converter enable
  input  wire logic         deepSleep,   // Low-power mode
  input  wire logic         hwScan,      // Scan mode
  input  wire logic         tempSel,     // Sensor routing
  input  wire logic         rangeClr,    // Flag clear
  input  wire logic         muxTemp,     // Sensor on mux
  input  wire logic         sampleOn,    // Sampling
  input  wire logic         busy,        // Converting
  input  wire logic         adcTick,     // Converter tick
  input  wire logic         done,        // Result pulse
  input  wire logic         rangeIrq,    // Sticky flag
  input  wire logic [7:0]   chanEn,      // Scan mask
  input  wire logic [7:0]   rangeFlags,  // Channel flags
  input  wire logic [2:0]   muxSel,      // Mux select
  input  wire logic [63:0]  sampTimes,   // Sample ticks
  input  wire logic [11:0]  limitLo,     // Low limit
  input  wire logic [11:0]  limitHi,     // High limit
  input  wire sasc_ref_t    refSelIn,    // Reference in
  input  wire sasc_ref_t    refSel,      // Reference out
  input  wire sasc_result_t lastResult   // Last result
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  localparam logic [7:0] SAMP_MIN = 8'(`SASC_CONV_CLKS - `SASC_RES_W);
  logic [7:0] sampTicks;
  logic [8:0] convTicks;
  logic [7:0] sampReq;
  logic [7:0] sampExp;
  assign sampReq = sampTimes[8*muxSel +: 8];
  assign sampExp = (sampReq < SAMP_MIN) ? SAMP_MIN : sampReq;
  // Ticks spent in the current acquisition
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !sampleOn)
      sampTicks <= 8'h00;
    else if (adcTick)
      sampTicks <= sampTicks + 8'h01;
  end
  // Ticks from start of sampling to result
  always_ff @(posedge mclk)
  begin
    if (!reset_n || done || !busy)
      convTicks <= 9'h000;
    else if (adcTick)
      convTicks <= convTicks + 9'h001;
  end
  AST_REF: assert property (refSel == refSelIn)
    else $error("reference mismatch");
  AST_TEMP: assert property (muxTemp |-> tempSel && muxSel == 3'h7)
    else $error("sensor on wrong channel");
  AST_OFF: assert property ((!enable || deepSleep) |=> !busy)
    else $error("busy while off");
  AST_TICK: assert property (adcTick |=> !adcTick [*8])
    else $error("converter tick too fast");
  AST_DONE: assert property (done |-> lastResult.valid ##1 !done)
    else $error("done pulse wrong");
  AST_STICKY: assert property (rangeIrq && !rangeClr |=> rangeIrq)
    else $error("range flag dropped");
  AST_RANGE: assert property (done && (lastResult.value < limitLo
    || lastResult.value > limitHi) |-> rangeIrq && rangeFlags[lastResult.chan])
    else $error("range miss");
  AST_SCAN: assert property (busy && hwScan && enable && !deepSleep
    && $stable(chanEn) && chanEn != 8'h00 |=> busy)
    else $error("gap in scan");
  AST_SAMP: assert property ($fell(sampleOn) && busy
    |-> sampTicks == sampExp)
    else $error("sample time wrong");
  AST_CONVLEN: assert property (done |-> convTicks >= 9'h012)
    else $error("conversion too short");
  cover property (done && hwScan);
  cover property (done && !hwScan);
  cover property ($rose(rangeIrq));
  cover property (muxTemp);
endmodule
bind sasc_sequencer sasc_sequencer_sva u_sva (.*);

/* tb/tb_top.sv */
// Self-checking bench for the sequencer
`timescale 1ns/1ps
`include "sasc_consts.svh"
module tb_top
  import sasc_pkg::*;
;
  logic mclk = 0, reset_n = 0, enable = 0, deepSleep = 0, hwScan = 0;
  logic fwStart = 0, tempSel = 0, rangeClr = 0, irqExp = 0;
  logic [7:0] chanEn = 8'h00, rangeFlags;
  logic [2:0] fwChan = 3'h0, rdChan = 3'h0, muxSel;
  sasc_ref_t refSelIn = REF_VDD, refSel;
  logic [4:0] clkDiv = 5'h0E;
  logic [63:0] sampTimes = 64'h0;
  logic [11:0] limitLo = 12'h000, limitHi = 12'hFFF, dacCode;
  logic [11:0] tempVal = 12'h5A5;
  logic [95:0] vals = 96'h0;
  logic coreBit, muxTemp, sampleOn, adcTick, busy, done, rangeIrq;
  sasc_result_t lastResult, rdResult;
  int errCount = 0, checks = 0, i, k;
  int order[$];
  logic [7:0] scanMask;
  logic [7:0] flagExp = 8'h00;
  logic [7:0] sampRun = 8'h00, sampSeen = 8'h00;
  logic [15:0] rnd = 16'h5355;
  localparam logic [7:0] SAMP_MIN = 8'(`SASC_CONV_CLKS - `SASC_RES_W);
  sasc_sequencer u_sasc_sequencer (.*);
  sasc_core_model u_sasc_core_model (.*);
  always #2 mclk = ~mclk;
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function logic [11:0] expv(input int ch);
    return (ch == 7 && tempSel) ? tempVal : vals[ch*12 +: 12];
  endfunction
  function logic [7:0] expSamp(input int ch);
    logic [7:0] req;
    req = sampTimes[ch*8 +: 8];
    return (req < SAMP_MIN) ? SAMP_MIN : req;
  endfunction
  task testDone;
    $display("checks=%0d errors=%0d", checks, errCount);
    if (errCount == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task cmpRes(input sasc_result_t g, input sasc_result_t e);
    checks++;
    if (g !== e)
    begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cmpNum(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cmpBit(input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      errCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task waitDone;
    int n;
    n = 0;
    @(negedge mclk);
    while (done !== 1'b1 && n < 2000)
    begin
      @(negedge mclk);
      n++;
    end
    if (done !== 1'b1)
    begin
      errCount++;
      testDone;
    end
  endtask
  task check(input int ch);
    if (expv(ch) < limitLo || expv(ch) > limitHi)
    begin
      irqExp = 1'b1;
      flagExp[ch] = 1'b1;
    end
    cmpRes(lastResult, {1'b1, ch[2:0], expv(ch)});
    cmpBit(rangeIrq, irqExp);
    cmpNum(rangeFlags, flagExp);
    cmpNum(sampSeen, expSamp(ch));
  endtask
  // Ticks seen in the latest acquisition
  always @(posedge mclk)
  begin
    if (sampleOn !== 1'b1)
      sampRun <= 8'h00;
    else if (adcTick)
      sampRun <= sampRun + 8'h01;
    if (sampleOn !== 1'b1 && sampRun != 8'h00)
      sampSeen <= sampRun;
  end
  initial
  begin
    @(posedge mclk);
    for (i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      vals[i*12 +: 12] <= rnd[11:0];
      sampTimes[i*8 +: 8] <= {4'h0, rnd[15:12]};
    end
    repeat (4) @(posedge mclk);
    reset_n <= 1;
    enable <= 1;
    tempSel <= 1;
    limitLo <= vals[11:0];
    limitHi <= vals[11:0];
    for (i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      fwChan <= i[2:0];
      fwStart <= 1;
      refSelIn <= sasc_ref_t'(i[1:0]);
      @(posedge mclk);
      fwStart <= 0;
      waitDone;
      check(i);
      cmpBit(refSel === sasc_ref_t'(i[1:0]), 1'b1);
    end
    for (i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      rdChan <= i[2:0];
      @(posedge mclk);
      @(negedge mclk);
      cmpRes(rdResult, {1'b1, i[2:0], expv(i)});
    end
    @(posedge mclk);
    rangeClr <= 1;
    @(posedge mclk);
    rangeClr <= 0;
    irqExp = 0;
    flagExp = 8'h00;
    @(negedge mclk);
    cmpBit(rangeIrq, 1'b0);
    cmpNum(rangeFlags, 8'h00);
    $display("test firmware done");
    scanMask = rnd[7:0] | 8'h81;
    k = 6;
    repeat (12)
    begin
      do k = (k + 1) % 8; while (!scanMask[k]);
      order.push_back(k);
    end
    @(posedge mclk);
    chanEn <= scanMask;
    hwScan <= 1;
    tempSel <= 0;
    repeat (12)
    begin
      waitDone;
      check(order.pop_front());
    end
    @(posedge mclk);
    deepSleep <= 1;
    @(posedge mclk);
    @(negedge mclk);
    cmpBit(busy, 1'b0);
    $display("test scan done");
    testDone;
  end
endmodule
